/* File: shared/dar_pkg.sv */
/*
 * constants shared by the dual alarm register block: register offsets,
 * writable field masks, transfer format codes and reset values.
 * assumes nothing of its surroundings; imported whole by each design file.
 */
package dar_pkg;

    // ==========================================================
    // register offsets (four-bit address pointer)
    localparam logic [3:0] DAR_OFS_WEEKLY_MINUTE = 4'h8;
    localparam logic [3:0] DAR_OFS_WEEKLY_HOUR   = 4'h9;
    localparam logic [3:0] DAR_OFS_WEEKLY_DAYS   = 4'hA;
    localparam logic [3:0] DAR_OFS_DAILY_MINUTE  = 4'hB;
    localparam logic [3:0] DAR_OFS_DAILY_HOUR    = 4'hC;

    // ==========================================================
    // implemented bits of each register; the rest read as zero
    localparam logic [7:0] DAR_MASK_MINUTE = 8'h7F;  // tens 6:4, units 3:0
    localparam logic [7:0] DAR_MASK_HOUR   = 8'h3F;  // twenties/pm 5, tens 4, units 3:0
    localparam logic [7:0] DAR_MASK_DAYS   = 8'h7F;  // one enable per weekday 6:0
    localparam logic [7:0] DAR_MASK_NONE   = 8'h00;
    localparam logic [7:0] DAR_REG_RESET   = 8'h00;

    // ==========================================================
    // field widths and the pm bit position
    localparam int DAR_MIN_W      = 7;
    localparam int DAR_HOUR_W     = 6;
    localparam int DAR_DAY_W      = 3;
    localparam int DAR_HOUR_PM_BIT = 5;

    localparam logic [2:0] DAR_DAY_INVALID = 3'h7;  // day counter never holds this

    // ==========================================================
    // command byte: upper nibble address, lower nibble format
    localparam logic [3:0] DAR_FMT_WRITE_ONE   = 4'h8;
    localparam logic [3:0] DAR_FMT_WRITE_BURST = 4'h0;
    localparam logic [3:0] DAR_FMT_READ_ONE    = 4'hC;
    localparam logic [3:0] DAR_FMT_READ_BURST  = 4'h4;

    // implemented bits of the register at an address; zero when unmapped
    function automatic logic [7:0] dar_field_mask(input logic [3:0] addr);
        logic [7:0] m;
        m = DAR_MASK_NONE;
        unique case (addr)
            DAR_OFS_WEEKLY_MINUTE: m = DAR_MASK_MINUTE;
            DAR_OFS_WEEKLY_HOUR:   m = DAR_MASK_HOUR;
            DAR_OFS_WEEKLY_DAYS:   m = DAR_MASK_DAYS;
            DAR_OFS_DAILY_MINUTE:  m = DAR_MASK_MINUTE;
            DAR_OFS_DAILY_HOUR:    m = DAR_MASK_HOUR;
            default:               m = DAR_MASK_NONE;
        endcase
        return m;
    endfunction

endpackage

/* File: design/dar_alarm_regs.sv */
/*
 * storage for the five alarm setting registers with masked writes and a
 * registered read port; also presents the stored fields to the comparators.
 * assumes write strobes and addresses come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_alarm_regs
    import dar_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic      [7:0] weekly_minute,
    output logic      [7:0] weekly_hour,
    output logic      [7:0] weekly_day_mask,
    output logic      [7:0] daily_minute,
    output logic      [7:0] daily_hour
);

    // ==========================================================
    // register array, upper bits dropped on write
    logic [7:0] mem [0:4];
    logic [7:0] wmask;

    assign wmask = dar_field_mask(wr_addr);

    // masked write; contents after power-up are unspecified, cleared here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 5; i++) begin
                mem[i] <= DAR_REG_RESET;
            end
        end else if (wr_en && (wmask != DAR_MASK_NONE)) begin
            mem[3'(wr_addr - DAR_OFS_WEEKLY_MINUTE)] <= wr_data & wmask;
        end
    end

    // registered read; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= DAR_REG_RESET;
        end else if (dar_field_mask(rd_addr) != DAR_MASK_NONE) begin
            rd_data <= mem[3'(rd_addr - DAR_OFS_WEEKLY_MINUTE)];
        end else begin
            rd_data <= DAR_REG_RESET;
        end
    end

    assign weekly_minute   = mem[0];
    assign weekly_hour     = mem[1];
    assign weekly_day_mask = mem[2];
    assign daily_minute    = mem[3];
    assign daily_hour      = mem[4];

endmodule

`default_nettype wire

/* File: design/dar_alarm_top.sv */
/*
 * dual alarm registers of a serial real-time clock: a three-wire serial
 * slave reaching the weekly and daily alarm registers, and the two alarm
 * comparators.
 * assumes ce, sclk and sio come from pins outside the clock domain, and the
 * current time inputs come from timekeeping logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_alarm_top
    import dar_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    input  wire logic                  sclk,
    input  wire logic                  sio_in,
    output logic                       sio_out,
    output logic                       sio_oe,
    input  wire logic [DAR_MIN_W-1:0]  cur_minute,
    input  wire logic [DAR_HOUR_W-1:0] cur_hour,
    input  wire logic [DAR_DAY_W-1:0]  cur_weekday,
    output logic                       weekly_match,
    output logic                       daily_match
);

    typedef enum logic [1:0] {
        DAR_ST_IDLE,
        DAR_ST_CMD,
        DAR_ST_WRITE,
        DAR_ST_READ
    } dar_state_t;

    // ==========================================================
    // pin synchronisers
    logic [1:0] ce_sync;
    logic [1:0] sclk_sync;
    logic [1:0] sio_sync;
    logic       ce_s;
    logic       sclk_s;
    logic       sio_s;
    logic       ce_d;
    logic       sclk_d;

    // two flops per pin, only the second stage is read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_sync   <= 2'h0;
            sclk_sync <= 2'h0;
            sio_sync  <= 2'h0;
        end else begin
            ce_sync   <= {ce_sync[0], ce};
            sclk_sync <= {sclk_sync[0], sclk};
            sio_sync  <= {sio_sync[0], sio_in};
        end
    end

    assign ce_s   = ce_sync[1];
    assign sclk_s = sclk_sync[1];
    assign sio_s  = sio_sync[1];

    // delayed copies for edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_d   <= 1'b0;
            sclk_d <= 1'b0;
        end else begin
            ce_d   <= ce_s;
            sclk_d <= sclk_s;
        end
    end

    // ==========================================================
    // edge timing: sclk level at ce rise picks the sampling edge
    logic ce_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic in_rising;   // 1: input on rising, output on falling
    logic in_edge;
    logic out_edge;

    assign ce_rise   = ce_s && !ce_d;
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign in_edge   = ce_s && !ce_rise && (in_rising ? sclk_rise : sclk_fall);
    assign out_edge  = ce_s && !ce_rise && (in_rising ? sclk_fall : sclk_rise);

    // latch the timing choice at the start of each frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_rising <= 1'b0;
        end else if (ce_rise) begin
            in_rising <= sclk_s;
        end
    end

    // ==========================================================
    // byte sequencer
    dar_state_t state;
    logic [2:0] bit_cnt;
    logic [6:0] rx;
    logic [7:0] rx_byte;
    logic       burst;
    logic [3:0] ptr;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [1:0] load_q;    // read data pipeline: pointer -> memory -> shifter
    logic       byte_done;

    assign rx_byte   = {rx, sio_s};
    assign byte_done = in_edge && (bit_cnt == 3'h7);

    // shift in msb first, decode command bytes, move data bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= DAR_ST_IDLE;
            bit_cnt <= 3'h0;
            rx      <= 7'h00;
            burst   <= 1'b0;
            ptr     <= 4'h0;
            wr_en   <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            load_q  <= 2'h0;
        end else begin
            wr_en  <= 1'b0;
            load_q <= {load_q[0], 1'b0};
            if (!ce_s) begin
                state   <= DAR_ST_IDLE;  // frame ends with ce low
                bit_cnt <= 3'h0;
            end else if (ce_rise) begin
                state   <= DAR_ST_CMD;
                bit_cnt <= 3'h0;
            end else if (in_edge) begin
                rx      <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done) begin
                    unique case (state)
                        DAR_ST_CMD: begin
                            ptr <= rx_byte[7:4];
                            if (rx_byte[3:0] == DAR_FMT_WRITE_ONE ||
                                rx_byte[3:0] == DAR_FMT_WRITE_BURST) begin
                                state <= DAR_ST_WRITE;
                                burst <= (rx_byte[3:0] == DAR_FMT_WRITE_BURST);
                            end else if (rx_byte[3:0] == DAR_FMT_READ_ONE ||
                                         rx_byte[3:0] == DAR_FMT_READ_BURST) begin
                                state  <= DAR_ST_READ;
                                burst  <= (rx_byte[3:0] == DAR_FMT_READ_BURST);
                                load_q <= 2'h1;
                            end
                        end
                        DAR_ST_WRITE: begin
                            wr_en   <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= rx_byte;  // upper bits masked in storage
                            if (burst) begin
                                ptr <= ptr + 4'h1;  // wraps f to 0
                            end else begin
                                state <= DAR_ST_CMD;
                            end
                        end
                        DAR_ST_READ: begin
                            if (burst) begin
                                ptr    <= ptr + 4'h1;
                                load_q <= 2'h1;
                            end else begin
                                state <= DAR_ST_CMD;
                            end
                        end
                        DAR_ST_IDLE: begin
                            state <= DAR_ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // register storage
    logic [7:0] rd_data;
    logic [7:0] weekly_minute;
    logic [7:0] weekly_hour;
    logic [7:0] weekly_day_mask;
    logic [7:0] daily_minute;
    logic [7:0] daily_hour;

    dar_alarm_regs dar_alarm_regs_i (
        .clk             (clk),
        .rst_b           (rst_b),
        .wr_en           (wr_en),
        .wr_addr         (wr_addr),
        .wr_data         (wr_data),
        .rd_addr         (ptr),
        .rd_data         (rd_data),
        .weekly_minute   (weekly_minute),
        .weekly_hour     (weekly_hour),
        .weekly_day_mask (weekly_day_mask),
        .daily_minute    (daily_minute),
        .daily_hour      (daily_hour)
    );

    // ==========================================================
    // read shifter and pin drive
    logic [7:0] tx;

    // load the addressed byte once the memory has presented it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx <= 8'h00;
        end else if (load_q[1]) begin
            tx <= rd_data;
        end
    end

    // present one bit per output edge, msb first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sio_out <= 1'b0;
        end else if (out_edge && state == DAR_ST_READ) begin
            sio_out <= tx[3'h7 - bit_cnt];
        end
    end

    // drive the pin only during the data phase of a read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sio_oe <= 1'b0;
        end else begin
            sio_oe <= ce_s && (state == DAR_ST_READ);
        end
    end

    // ==========================================================
    // alarm comparison; bit5 compares as is, so pm flag and twenties digit
    // both follow the same bcd coding in either hour mode
    logic weekly_day_hit;
    logic weekly_time_hit;
    logic daily_time_hit;

    assign weekly_day_hit  = (cur_weekday != DAR_DAY_INVALID) &&
                             (weekly_day_mask[DAR_DAY_W'(cur_weekday)]) &&
                             (weekly_day_mask[6:0] != 7'h00);
    assign weekly_time_hit = (cur_minute == weekly_minute[DAR_MIN_W-1:0]) &&
                             (cur_hour == weekly_hour[DAR_HOUR_W-1:0]);
    assign daily_time_hit  = (cur_minute == daily_minute[DAR_MIN_W-1:0]) &&
                             (cur_hour == daily_hour[DAR_HOUR_W-1:0]);

    // registered match levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            weekly_match <= 1'b0;
            daily_match  <= 1'b0;
        end else begin
            weekly_match <= weekly_time_hit && weekly_day_hit;
            daily_match  <= daily_time_hit;
        end
    end

endmodule

`default_nettype wire

/* File: verification/dar_alarm_properties.sv */
/*
 * checker for the alarm comparator outputs of dar_alarm_top.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_alarm_properties
    import dar_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  ce,
    input wire logic                  sclk,
    input wire logic                  sio_in,
    input wire logic                  sio_out,
    input wire logic                  sio_oe,
    input wire logic [DAR_MIN_W-1:0]  cur_minute,
    input wire logic [DAR_HOUR_W-1:0] cur_hour,
    input wire logic [DAR_DAY_W-1:0]  cur_weekday,
    input wire logic                  weekly_match,
    input wire logic                  daily_match
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // link idle, so the alarm settings cannot move under us
    sequence s_idle;
        !ce [*3];
    endsequence
    sequence s_dl_same;
        s_idle ##0 (daily_match && $stable(cur_minute) && $stable(cur_hour));
    endsequence
    sequence s_wk_same;
        s_dl_same ##0 (weekly_match && $stable(cur_weekday));
    endsequence

    property p_bad_day;
        cur_weekday == DAR_DAY_INVALID |=> !weekly_match;
    endproperty
    property p_wk_past_day;
        weekly_match |-> $past(cur_weekday) != DAR_DAY_INVALID;
    endproperty
    property p_dl_hold;
        s_dl_same |=> daily_match;
    endproperty
    property p_wk_hold;
        s_wk_same |=> weekly_match;
    endproperty
    property p_dl_min;
        s_idle ##0 (daily_match && $changed(cur_minute)) |=> !daily_match;
    endproperty
    property p_dl_hour;
        s_idle ##0 (daily_match && $changed(cur_hour)) |=> !daily_match;
    endproperty
    property p_wk_min;
        s_idle ##0 (weekly_match && $changed(cur_minute)) |=> !weekly_match;
    endproperty
    property p_wk_hour;
        s_idle ##0 (weekly_match && $changed(cur_hour)) |=> !weekly_match;
    endproperty

    a_bad_day: assert property (p_bad_day)
        else $error("weekly match on invalid weekday");
    a_wk_past_day: assert property (p_wk_past_day)
        else $error("weekly match after invalid weekday");
    a_dl_hold: assert property (p_dl_hold)
        else $error("daily match lost with time unchanged");
    a_wk_hold: assert property (p_wk_hold)
        else $error("weekly match lost with time unchanged");
    a_dl_min: assert property (p_dl_min)
        else $error("daily match kept after minute change");
    a_dl_hour: assert property (p_dl_hour)
        else $error("daily match kept after hour change");
    a_wk_min: assert property (p_wk_min)
        else $error("weekly match kept after minute change");
    a_wk_hour: assert property (p_wk_hour)
        else $error("weekly match kept after hour change");
endmodule

bind dar_alarm_top dar_alarm_properties dar_alarm_properties_i (
    .clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe), .cur_minute(cur_minute),
    .cur_hour(cur_hour), .cur_weekday(cur_weekday),
    .weekly_match(weekly_match), .daily_match(daily_match)
);

`default_nettype wire

/* File: verification/dar_host_model.sv */
/*
 * host side of the three-wire link: frames, sclk and the shared data wire.
 * assumes the device drives data only while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_host_model (
    output var logic ce,
    output var logic sclk,
    output logic     sio_in,
    input wire logic sio_out,
    input wire logic sio_oe
);
    logic hd   = 1'b0;
    logic hoe  = 1'b0;
    logic last = 1'b0;
    logic sclk_idle = 1'b0;  // sclk level between frames; picks the link timing

    // wire level; an undriven wire shows the inverse of its last level
    assign sio_in = sio_oe ? sio_out : (hoe ? hd : ~last);
    always @(sio_in) if (sio_oe | hoe) last = sio_in;

    initial begin
        ce = 1'b0;
        sclk = 1'b0;
    end

    // ==========================================================
    // first toggle is the output edge, second the sampling edge, msb first;
    // data moves only on the output edge so it is settled when it is taken
    task automatic byte_io(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #62.5 sclk = ~sclk;
            hoe = drv;
            hd = tx[i];
            #50 rx[i] = sio_in;
            #12.5 sclk = ~sclk;
        end
    endtask

    // frame open and close; sclk stands at its idle level between frames
    task automatic start();
        sclk = sclk_idle;
        #100 ce <= 1'b1;
        #100;
    endtask
    task automatic stop();
        #100 ce <= 1'b0;
        hoe = 1'b0;
        #200;
    endtask
endmodule

`default_nettype wire

/* File: verification/tb.sv */
/*
 * self-checking bench for dar_alarm_top over its serial link.
 * assumes the host model for the link and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import dar_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       ce, sclk, sio_in, sio_out, sio_oe;
    logic [6:0] cur_minute = 7'h00;
    logic [5:0] cur_hour = 6'h00;
    logic [2:0] cur_weekday = 3'h0;
    logic       weekly_match, daily_match;
    logic [7:0] bq [5];
    logic [7:0] r;
    logic [7:0] mask_q [5] = '{8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F};
    logic [7:0] set_q [5] = '{8'h59, 8'h32, 8'h41, 8'h30, 8'h12};
    int         miscompares = 0;
    int         comparisons = 0;

    dar_alarm_top dar_alarm_top_i (.clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .cur_minute(cur_minute),
        .cur_hour(cur_hour), .cur_weekday(cur_weekday),
        .weekly_match(weekly_match), .daily_match(daily_match));
    dar_host_model dar_host_model_i (.ce(ce), .sclk(sclk), .sio_in(sio_in),
        .sio_out(sio_out), .sio_oe(sio_oe));

    always #5 clk = ~clk;

    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one-byte access: command then one data byte
    task automatic one(input logic [3:0] a, input logic [3:0] f, input logic [7:0] d);
        dar_host_model_i.start();
        dar_host_model_i.byte_io({a, f}, 1'b1, r);
        dar_host_model_i.byte_io(d, f == DAR_FMT_WRITE_ONE, r);
        dar_host_model_i.stop();
    endtask

    // burst of five bytes from the weekly minute register
    task automatic burst(input logic [3:0] f, input logic drv);
        logic [7:0] x;
        dar_host_model_i.start();
        dar_host_model_i.byte_io({DAR_OFS_WEEKLY_MINUTE, f}, 1'b1, x);
        foreach (bq[i]) begin
            dar_host_model_i.byte_io(bq[i], drv, x);
            if (!drv) bq[i] = x;
        end
        dar_host_model_i.stop();
    endtask

    // present a time, let the registered compare settle, check both
    task automatic tm(input logic [6:0] m, input logic [5:0] h, input logic [2:0] d,
                      input logic ew, input logic ed);
        @(posedge clk);
        cur_minute <= m;
        cur_hour <= h;
        cur_weekday <= d;
        repeat (4) @(posedge clk);
        #1 check({6'h00, weekly_match, daily_match}, {6'h00, ew, ed});
    endtask

    // watchdog well beyond the expected run of about 67 us
    initial begin
        #200us;
        miscompares++;
        give_verdict();
    end

    // ==========================================================
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        // cleared state of the five mapped registers reads back zero
        for (int a = 8; a <= 12; a++) begin
            one(a[3:0], DAR_FMT_READ_ONE, 8'h00);
            check(r, DAR_REG_RESET);
        end
        // all ones written; only implemented bits stay
        for (int a = 8; a <= 12; a++) begin
            one(a[3:0], DAR_FMT_WRITE_ONE, 8'hFF);
            one(a[3:0], DAR_FMT_READ_ONE, 8'h00);
            check(r, mask_q[a-8]);
        end
        one(4'h3, DAR_FMT_WRITE_ONE, 8'hFF);
        one(4'h3, DAR_FMT_READ_ONE, 8'h00);
        check(r, 8'h00);
        // noon and midnight encodings through burst write and read
        bq = set_q;
        burst(DAR_FMT_WRITE_BURST, 1'b1);
        bq = '{default: 8'h00};
        burst(DAR_FMT_READ_BURST, 1'b0);
        foreach (bq[i]) check(bq[i], set_q[i]);
        // unknown format byte is skipped, next byte is a command
        dar_host_model_i.start();
        dar_host_model_i.byte_io(8'hC1, 1'b1, r);
        dar_host_model_i.byte_io({DAR_OFS_DAILY_HOUR, DAR_FMT_READ_ONE}, 1'b1, r);
        dar_host_model_i.byte_io(8'h00, 1'b0, r);
        dar_host_model_i.stop();
        check(r, 8'h12);
        // weekly: days 0 and 6 enabled, pm noon 32
        tm(7'h59, 6'h32, 3'h0, 1'b1, 1'b0);
        tm(7'h59, 6'h32, 3'h6, 1'b1, 1'b0);
        tm(7'h58, 6'h32, 3'h6, 1'b0, 1'b0);
        tm(7'h59, 6'h32, 3'h6, 1'b1, 1'b0);
        tm(7'h59, 6'h12, 3'h6, 1'b0, 1'b0);
        tm(7'h59, 6'h32, 3'h3, 1'b0, 1'b0);
        tm(7'h59, 6'h32, 3'h7, 1'b0, 1'b0);
        // daily: midnight 12 versus noon 32
        tm(7'h30, 6'h12, 3'h7, 1'b0, 1'b1);
        tm(7'h31, 6'h12, 3'h0, 1'b0, 1'b0);
        tm(7'h30, 6'h12, 3'h0, 1'b0, 1'b1);
        tm(7'h30, 6'h32, 3'h0, 1'b0, 1'b0);
        // empty day mask silences the weekly alarm
        one(DAR_OFS_WEEKLY_DAYS, DAR_FMT_WRITE_ONE, 8'h00);
        tm(7'h59, 6'h32, 3'h0, 1'b0, 1'b0);
        // sclk high at ce rise: taken on rising edge, output on falling
        dar_host_model_i.sclk_idle = 1'b1;
        one(DAR_OFS_DAILY_MINUTE, DAR_FMT_WRITE_ONE, 8'hA5);
        one(DAR_OFS_DAILY_MINUTE, DAR_FMT_READ_ONE, 8'h00);
        check(r, 8'h25);
        tm(7'h25, 6'h12, 3'h0, 1'b0, 1'b1);
        give_verdict();
    end
endmodule

`default_nettype wire
